//--- rtl/ssr_host.sv
// Serial SRAM master end: frames opcode, address and data bytes on the link
`timescale 1ns/100ps
`default_nettype none
module ssr_host #(
  parameter int HALF = ssr_pkg::SCK_HALF_CYC
) (
  // Clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST_B,
  // Link
  ssr_link_if.host        LNK,
  // Command
  input  wire logic       START,
  input  wire logic [7:0] OPCODE,
  input  wire logic [15:0] ADDR,
  input  wire logic [7:0] NBYTES,
  input  wire logic       PAUSE,
  output logic            BUSY,
  // Write data
  input  wire logic [7:0] TX_DATA,
  output logic            TX_TAKE,
  // Read data
  output logic [7:0]      RX_DATA,
  output logic            RX_VALID
);
  ssr_pkg::ssr_hst_t st_q;
  logic [3:0]        div_q;
  logic              sck_q;
  logic              cs_n_q;
  logic              hold_n_q;
  logic              si_q;
  logic [7:0]        tx_sh_q;
  logic [7:0]        rx_sh_q;
  logic [2:0]        bit_q;
  logic [8:0]        byte_q;
  logic [8:0]        last_q;
  logic [1:0]        hdr_q;
  logic              rd_q;
  logic [15:0]       addr_q;
  logic              so_m_q;
  logic              so_s_q;
  logic              busy_q;
  logic              take_q;
  logic              rxv_q;
  logic [7:0]        rxd_q;

  wire               mem_op   = (OPCODE == ssr_pkg::OP_READ) || (OPCODE == ssr_pkg::OP_WRITE);
  wire               rd_op    = (OPCODE == ssr_pkg::OP_READ) ||
                                (OPCODE == ssr_pkg::READ_STATUS_CMD);
  wire [1:0]         hdr_w    = mem_op ? 2'h3 : 2'h1;
  wire               div_end  = div_q == 4'(HALF - 1);
  wire [8:0]         byte_n   = byte_q + 9'h001;
  wire               data_cur = byte_q >= {7'h00, hdr_q};
  wire               data_nxt = byte_n >= {7'h00, hdr_q};
  wire [7:0]         rx_full  = {rx_sh_q[6:0], so_s_q};
  // Status commands carry no address, so their first byte after the opcode is data
  wire [7:0]         nxt_byte = (byte_n == 9'h001 && hdr_q == 2'h3) ? addr_q[15:8] :
                                (byte_n == 9'h002 && hdr_q == 2'h3) ? addr_q[7:0] : TX_DATA;

  // Two-flop synchroniser on the returning data line
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      so_m_q <= 1'b0;
      so_s_q <= 1'b0;
    end else begin
      so_m_q <= LNK.so_line;
      so_s_q <= so_m_q;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q     <= ssr_pkg::H_IDLE;
      div_q    <= 4'h0;
      sck_q    <= 1'b0;
      cs_n_q   <= 1'b1;
      hold_n_q <= 1'b1;
      si_q     <= 1'b0;
      tx_sh_q  <= 8'h00;
      rx_sh_q  <= 8'h00;
      bit_q    <= 3'h0;
      byte_q   <= 9'h000;
      last_q   <= 9'h000;
      hdr_q    <= 2'h1;
      rd_q     <= 1'b0;
      addr_q   <= 16'h0000;
      busy_q   <= 1'b0;
      take_q   <= 1'b0;
      rxv_q    <= 1'b0;
      rxd_q    <= 8'h00;
    end else begin
      take_q <= 1'b0;
      rxv_q  <= 1'b0;
      case (st_q)
        ssr_pkg::H_IDLE: begin
          if (START) begin
            cs_n_q  <= 1'b0;
            tx_sh_q <= OPCODE;
            si_q    <= OPCODE[7];
            addr_q  <= ADDR;
            hdr_q   <= hdr_w;
            rd_q    <= rd_op;
            last_q  <= {7'h00, hdr_w} + {1'b0, NBYTES} - 9'h001;
            byte_q  <= 9'h000;
            bit_q   <= 3'h0;
            div_q   <= 4'h0;
            busy_q  <= 1'b1;
            st_q    <= ssr_pkg::H_SETUP;
          end
        end
        ssr_pkg::H_SETUP: begin
          if (div_q == 4'(ssr_pkg::CSS_CYC - 1)) begin
            div_q <= 4'h0;
            st_q  <= ssr_pkg::H_SHIFT;
          end else begin
            div_q <= div_q + 4'h1;
          end
        end
        ssr_pkg::H_SHIFT: begin
          if (!sck_q) begin
            // Hold only moves while the clock is low
            if (PAUSE) begin
              hold_n_q <= 1'b0;
              div_q    <= 4'h0;
            end else if (!hold_n_q) begin
              hold_n_q <= 1'b1;
            end else if (div_end) begin
              sck_q <= 1'b1;
              div_q <= 4'h0;
            end else begin
              div_q <= div_q + 4'h1;
            end
          end else if (div_end) begin
            sck_q   <= 1'b0;
            div_q   <= 4'h0;
            rx_sh_q <= rx_full;
            bit_q   <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              byte_q <= byte_n;
              if (rd_q && data_cur) begin
                rxd_q <= rx_full;
                rxv_q <= 1'b1;
              end
              if (byte_q == last_q) begin
                st_q <= ssr_pkg::H_END;
              end else begin
                tx_sh_q <= nxt_byte;
                si_q    <= nxt_byte[7];
                take_q  <= data_nxt && !rd_q;
              end
            end else begin
              tx_sh_q <= {tx_sh_q[6:0], 1'b0};
              si_q    <= tx_sh_q[6];
            end
          end else begin
            div_q <= div_q + 4'h1;
          end
        end
        ssr_pkg::H_END: begin
          if (div_q == 4'(ssr_pkg::CSH_CYC - 1)) begin
            cs_n_q <= 1'b1;
            busy_q <= 1'b0;
            div_q  <= 4'h0;
            st_q   <= ssr_pkg::H_IDLE;
          end else begin
            div_q <= div_q + 4'h1;
          end
        end
        default: st_q <= ssr_pkg::H_IDLE;
      endcase
    end
  end

  assign LNK.sck    = sck_q;
  assign LNK.cs_n   = cs_n_q;
  assign LNK.hold_n = hold_n_q;
  assign LNK.si     = si_q;
  assign BUSY       = busy_q;
  assign TX_TAKE    = take_q;
  assign RX_DATA    = rxd_q;
  assign RX_VALID   = rxv_q;
endmodule
`default_nettype wire

//--- shared/ssr_pkg.sv
// Shared constants and types for the serial SRAM link and both of its ends
package ssr_pkg;
  // Array geometry
  localparam int ADDR_W    = 15;
  localparam int PAGE_BITS = 5;
  localparam int DEPTH     = 32768;
  // Opcodes
  localparam logic [7:0] OP_READ          = 8'h03;
  localparam logic [7:0] OP_WRITE         = 8'h02;
  localparam logic [7:0] READ_STATUS_CMD  = 8'h05;
  localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;
  // Status register: mode field position, codes and reset value
  localparam int         SR_MODE_LSB = 6;
  localparam logic [1:0] MODE_WORD   = 2'h0;
  localparam logic [1:0] MODE_PAGE   = 2'h2;
  localparam logic [1:0] MODE_BURST  = 2'h1;
  localparam logic [7:0] SR_WMASK    = 8'hC0;
  localparam logic [7:0] SR_RESET    = 8'h00;
  // Link timing, master side
  localparam int CLK_NS      = 10;
  localparam int T_CSS_NS    = 25;
  localparam int T_CSH_NS    = 50;
  localparam int T_HALF_NS   = 40;
  localparam int CSS_CYC     = (T_CSS_NS + CLK_NS - 1) / CLK_NS;
  localparam int CSH_CYC     = (T_CSH_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCK_HALF_CYC = (T_HALF_NS + CLK_NS - 1) / CLK_NS;
  // Device sequencer states
  typedef enum logic [2:0] {
    D_CMD = 3'b000,
    D_ARD = 3'b001,
    D_MRD = 3'b011,
    D_SRD = 3'b010,
    D_SWR = 3'b110,
    D_IGN = 3'b111,
    D_AWR = 3'b100,
    D_MWR = 3'b101
  } ssr_dst_t;
  // Master sequencer states
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SETUP = 2'b01,
    H_SHIFT = 2'b11,
    H_END   = 2'b10
  } ssr_hst_t;
endpackage

//--- shared/ssr_link_if.sv
// Serial link between the memory device and its master
`timescale 1ns/100ps
`default_nettype none
interface ssr_link_if;
  logic sck;
  logic cs_n;
  logic hold_n;
  logic si;
  logic so;
  logic so_oe_n;
  // Level seen on the data-out wire; an undriven wire reads low
  wire  so_line = so_oe_n ? 1'b0 : so;
  modport dev  (input sck, input cs_n, input hold_n, input si, output so, output so_oe_n);
  modport host (output sck, output cs_n, output hold_n, output si, input so_line,
                input so_oe_n);
endinterface
`default_nettype wire

//--- rtl/ssr_dev.sv
// Serial SRAM device end: opcode decode, addressing modes and storage array
`timescale 1ns/100ps
`default_nettype none
module ssr_dev #(
  parameter int ADDR_W = ssr_pkg::ADDR_W,
  parameter int DEPTH  = ssr_pkg::DEPTH
) (
  // Link
  ssr_link_if.dev         LNK,
  // Reset
  input  wire logic       RST_B,
  // Mode currently held in the status register
  output logic [1:0]      MODE
);
  logic [7:0]        mem [DEPTH];
  ssr_pkg::ssr_dst_t state_q;
  ssr_pkg::ssr_dst_t state_d;
  logic [3:0]        bit_q;
  logic [3:0]        bit_d;
  logic [14:0]       sh_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [ADDR_W-1:0] nxt_addr;
  logic [7:0]        tx_q;
  logic [7:0]        tx_d;
  logic              drive_q;
  logic              drive_d;
  logic              mem_we;
  logic              sr_we;
  logic [7:0]        status_q;
  logic              so_q;
  logic              oe_n_q;

  // Select high holds the whole sequencer in standby
  wire               link_rst_n = RST_B & ~LNK.cs_n;
  wire               run        = LNK.hold_n;
  wire [15:0]        in_w       = {sh_q, LNK.si};
  wire [7:0]         byte_w     = in_w[7:0];
  wire               last8      = bit_q[2:0] == 3'h7;
  wire               last16     = bit_q == 4'hF;
  wire [1:0]         mode_w     = status_q[ssr_pkg::SR_MODE_LSB +: 2];
  wire [ADDR_W-1:0]  addr_in    = in_w[ADDR_W-1:0];
  wire [ADDR_W-1:0]  page_inc   = {addr_q[ADDR_W-1:ssr_pkg::PAGE_BITS],
                                   addr_q[ssr_pkg::PAGE_BITS-1:0] + 5'h01};
  wire [ADDR_W-1:0]  burst_inc  = addr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
  wire [2:0]         out_idx    = 3'h7 - bit_q[2:0];

  // Next address per addressing mode
  always_comb begin
    case (mode_w)
      ssr_pkg::MODE_PAGE:  nxt_addr = page_inc;
      ssr_pkg::MODE_BURST: nxt_addr = burst_inc;
      default:             nxt_addr = addr_q;
    endcase
  end

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    bit_d   = bit_q + 4'h1;
    addr_d  = addr_q;
    tx_d    = tx_q;
    drive_d = drive_q;
    mem_we  = 1'b0;
    sr_we   = 1'b0;
    case (state_q)
      ssr_pkg::D_CMD: begin
        if (last8) begin
          bit_d = 4'h0;
          case (byte_w)
            ssr_pkg::OP_READ:  state_d = ssr_pkg::D_ARD;
            ssr_pkg::OP_WRITE: state_d = ssr_pkg::D_AWR;
            ssr_pkg::READ_STATUS_CMD: begin
              state_d = ssr_pkg::D_SRD;
              tx_d    = status_q;
              drive_d = 1'b1;
            end
            ssr_pkg::WRITE_STATUS_CMD: state_d = ssr_pkg::D_SWR;
            default:           state_d = ssr_pkg::D_IGN;
          endcase
        end
      end
      ssr_pkg::D_ARD: begin
        if (last16) begin
          bit_d   = 4'h0;
          addr_d  = addr_in;
          tx_d    = mem[addr_in];
          drive_d = 1'b1;
          state_d = ssr_pkg::D_MRD;
        end
      end
      ssr_pkg::D_AWR: begin
        if (last16) begin
          bit_d   = 4'h0;
          addr_d  = addr_in;
          state_d = ssr_pkg::D_MWR;
        end
      end
      ssr_pkg::D_MRD: begin
        if (last8) begin
          bit_d  = 4'h0;
          addr_d = nxt_addr;
          tx_d   = mem[nxt_addr];
        end
      end
      ssr_pkg::D_MWR: begin
        if (last8) begin
          bit_d  = 4'h0;
          mem_we = 1'b1;
          addr_d = nxt_addr;
        end
      end
      ssr_pkg::D_SRD: begin
        if (last8) begin
          bit_d = 4'h0;
          tx_d  = status_q;
        end
      end
      ssr_pkg::D_SWR: begin
        if (last8) begin
          bit_d   = 4'h0;
          sr_we   = 1'b1;
          state_d = ssr_pkg::D_IGN;
        end
      end
      default: begin
        bit_d = bit_q;
      end
    endcase
  end

  // Input side: everything advances on the rising edge unless held
  always_ff @(posedge LNK.sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_q <= ssr_pkg::D_CMD;
      bit_q   <= 4'h0;
      sh_q    <= 15'h0000;
      addr_q  <= '0;
      tx_q    <= 8'h00;
      drive_q <= 1'b0;
    end else if (run) begin
      state_q <= state_d;
      bit_q   <= bit_d;
      sh_q    <= in_w[14:0];
      addr_q  <= addr_d;
      tx_q    <= tx_d;
      drive_q <= drive_d;
    end
  end

  // Storage array has no reset
  always_ff @(posedge LNK.sck) begin
    if (mem_we && run && link_rst_n) begin
      mem[addr_q] <= byte_w;
    end
  end

  // Status survives deselect; only the mode field is kept
  always_ff @(posedge LNK.sck or negedge RST_B) begin
    if (!RST_B) begin
      status_q <= ssr_pkg::SR_RESET;
    end else if (sr_we && run && !LNK.cs_n) begin
      status_q <= byte_w & ssr_pkg::SR_WMASK;
    end
  end

  // Output side: data and enable change on the falling edge
  always_ff @(negedge LNK.sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      so_q   <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (run) begin
      so_q   <= tx_q[out_idx];
      oe_n_q <= ~drive_q;
    end else begin
      oe_n_q <= 1'b1;
    end
  end

  assign LNK.so      = so_q;
  assign LNK.so_oe_n = oe_n_q;
  assign MODE        = status_q[ssr_pkg::SR_MODE_LSB +: 2];
endmodule
`default_nettype wire

//--- verif/ssr_link_props.sv
// Concurrent checks on the serial link between the master and memory ends
`timescale 1ns/100ps
`default_nettype none
module ssr_link_props (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // Link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe_n
);
  logic [7:0] op_q;
  logic [5:0] bits_q;
  wire        is_rd = op_q == ssr_pkg::OP_READ;
  wire        is_rs = op_q == ssr_pkg::READ_STATUS_CMD;
  // Unpaused rising edges of the frame, and the opcode they carried
  always_ff @(posedge sck or posedge cs_n or negedge RST_B) begin
    if (!RST_B || cs_n) begin
      op_q   <= 8'h00;
      bits_q <= 6'h00;
    end else if (hold_n) begin
      if (bits_q < 6'h08) op_q <= {op_q[6:0], si};
      if (bits_q != 6'h3F) bits_q <= bits_q + 6'h01;
    end
  end
  sequence s_sel;
    $fell(cs_n);
  endsequence
  sequence s_setup;
    !sck [*2];
  endsequence
  property p_cs_setup;
    @(posedge SYS_CLK) disable iff (!RST_B) s_sel |-> s_setup;
  endproperty
  a_cs_setup: assert property (p_cs_setup) else $error("clock rose right at select");
  property p_idle;
    @(posedge SYS_CLK) disable iff (!RST_B) cs_n |-> !sck && hold_n && so_oe_n;
  endproperty
  a_idle: assert property (p_idle) else $error("link not idle in standby");
  property p_so_edge;
    @(posedge SYS_CLK) disable iff (!RST_B)
      !cs_n && !$past(cs_n) && sck == $past(sck) |-> $stable(so);
  endproperty
  a_so_edge: assert property (p_so_edge) else $error("data out moved off a fall");
  property p_hdr_quiet;
    @(posedge sck) disable iff (!RST_B || cs_n)
      bits_q < 6'h08 || !(is_rd || is_rs) || (is_rd && bits_q < 6'h18) |-> so_oe_n;
  endproperty
  a_hdr_quiet: assert property (p_hdr_quiet) else $error("data out driven early");
  property p_rd_drive;
    @(posedge sck) disable iff (!RST_B || cs_n) is_rd && bits_q >= 6'h18 |-> !so_oe_n;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read data not driven");
  property p_rs_drive;
    @(posedge sck) disable iff (!RST_B || cs_n) is_rs && bits_q >= 6'h08 |-> !so_oe_n;
  endproperty
  a_rs_drive: assert property (p_rs_drive) else $error("status not driven");
  property p_pause_low;
    @(posedge SYS_CLK) disable iff (!RST_B) $fell(hold_n) |-> !sck && !cs_n;
  endproperty
  a_pause_low: assert property (p_pause_low) else $error("pause begun with clock high");
  property p_resume_low;
    @(posedge SYS_CLK) disable iff (!RST_B) $rose(hold_n) |-> !sck;
  endproperty
  a_resume_low: assert property (p_resume_low) else $error("resume with clock high");
endmodule
`default_nettype wire

//--- verif/ssr_tb.sv
// Self-checking bench joining the master and memory ends over one link
`timescale 1ns/100ps
`default_nettype none
module spi_serial_sram_slave_tb;
  logic        SYS_CLK = 1'b0;
  logic        RST_B   = 1'b1;
  logic        START   = 1'b0;
  logic [7:0]  OPCODE  = 8'h00;
  logic [15:0] ADDR    = 16'h0000;
  logic [7:0]  NBYTES  = 8'h00;
  logic        PAUSE   = 1'b0;
  logic [7:0]  TX_DATA = 8'h00;
  logic        BUSY;
  logic        TX_TAKE;
  logic        RX_VALID;
  logic [7:0]  RX_DATA;
  logic [1:0]  MODE;
  int          mismatches  = 0;
  int          checks_done = 0;
  int          nbits       = 0;
  int          want_bits   = 0;
  logic [7:0]  want_op     = 8'h00;
  logic [7:0]  opw         = 8'h00;
  logic [31:0] rnd         = 32'h0000_3ac1;
  logic [7:0]  exq[$];
  logic [7:0]  txq[$];
  logic [7:0]  mem[int];
  always #5 SYS_CLK = ~SYS_CLK;
  ssr_link_if lnk ();
  ssr_dev ssr_dev_i (.LNK(lnk.dev), .RST_B(RST_B), .MODE(MODE));
  ssr_host ssr_host_i (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .LNK(lnk.host), .START(START), .OPCODE(OPCODE),
    .ADDR(ADDR), .NBYTES(NBYTES), .PAUSE(PAUSE), .BUSY(BUSY), .TX_DATA(TX_DATA),
    .TX_TAKE(TX_TAKE), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID)
  );
  ssr_link_props ssr_link_props_i (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .sck(lnk.sck), .cs_n(lnk.cs_n), .hold_n(lnk.hold_n),
    .si(lnk.si), .so(lnk.so), .so_oe_n(lnk.so_oe_n)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [14:0] nxt(input logic [14:0] a, input logic [1:0] m);
    if (m == ssr_pkg::MODE_PAGE) return {a[14:5], a[4:0] + 5'h01};
    if (m == ssr_pkg::MODE_BURST) return a + 15'h0001;
    return a;
  endfunction
  // Issue one command and wait, bounded, for the frame to close
  task automatic frame(input logic [7:0] op, input logic [15:0] a, input int n, input bit stall);
    int k;
    want_op = op;
    want_bits = 8 * n + ((op == ssr_pkg::OP_READ || op == ssr_pkg::OP_WRITE) ? 24 : 8);
    OPCODE = op;
    ADDR = a;
    NBYTES = n[7:0];
    START = 1'b1;
    @(negedge SYS_CLK);
    START = 1'b0;
    @(negedge SYS_CLK);
    if (stall) begin
      repeat (250) @(negedge SYS_CLK);
      PAUSE = 1'b1;
      repeat (60) @(negedge SYS_CLK);
      PAUSE = 1'b0;
    end
    k = 0;
    while (BUSY !== 1'b0 && k < 20000) begin
      @(negedge SYS_CLK);
      k++;
    end
    if (k == 20000) begin
      mismatches++;
      wrap_up();
    end
    @(negedge SYS_CLK);
  endtask
  // Wire view: opcode bits in order and bit count per frame
  always @(negedge lnk.cs_n) nbits = 0;
  always @(posedge lnk.sck) begin
    if (!lnk.cs_n && lnk.hold_n) begin
      if (nbits < 8) opw = {opw[6:0], lnk.si};
      nbits++;
    end
  end
  always @(posedge lnk.cs_n) begin
    if (RST_B) begin
      check(opw, want_op);
      check(8'(nbits), 8'(want_bits));
    end
  end
  always @(negedge SYS_CLK) begin
    if (RX_VALID === 1'b1) check(RX_DATA, exq.size() > 0 ? exq.pop_front() : 8'hxx);
    if (TX_TAKE === 1'b1 && txq.size() > 0) void'(txq.pop_front());
    TX_DATA = txq.size() > 0 ? txq[0] : 8'h00;
  end
  initial begin
    logic [1:0]  modes[3];
    logic [15:0] base[3];
    logic [14:0] a;
    modes = '{ssr_pkg::MODE_WORD, ssr_pkg::MODE_PAGE, ssr_pkg::MODE_BURST};
    base = '{16'h0123, 16'h0BDE, 16'hFFFE};
    // Reset falls after time zero so every asynchronous reset sees an edge
    #1 RST_B = 1'b0;
    repeat (4) @(negedge SYS_CLK);
    RST_B = 1'b1;
    check({6'h00, MODE}, 8'h00);
    exq.push_back(8'h00);
    frame(ssr_pkg::READ_STATUS_CMD, 16'h0000, 1, 1'b0);
    for (int i = 0; i < 3; i++) begin
      txq.push_back({modes[i], 6'h00});
      frame(ssr_pkg::WRITE_STATUS_CMD, 16'h0000, 1, 1'b0);
      check({6'h00, MODE}, {6'h00, modes[i]});
      exq.push_back({modes[i], 6'h00});
      frame(ssr_pkg::READ_STATUS_CMD, 16'h0000, 1, 1'b0);
      a = base[i][14:0];
      for (int j = 0; j < 4; j++) begin
        rnd = xs(rnd);
        txq.push_back(rnd[7:0]);
        mem[a] = rnd[7:0];
        a = nxt(a, modes[i]);
      end
      frame(ssr_pkg::OP_WRITE, base[i], 4, i == 1);
      a = base[i][14:0];
      for (int j = 0; j < 4; j++) begin
        exq.push_back(mem[a]);
        a = nxt(a, modes[i]);
      end
      frame(ssr_pkg::OP_READ, base[i], 4, 1'b0);
    end
    // Unknown opcode: rest of frame ignored, status untouched
    frame(8'h81, 16'h0000, 1, 1'b0);
    check({6'h00, MODE}, {6'h00, ssr_pkg::MODE_BURST});
    check(8'(txq.size()), 8'h00);
    check(8'(exq.size()), 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
